// *** eliu_asserts.sv ***
// port checks of the event link interrupt unit
// assumes it is bound into eliu_event_link_interrupt_unit
`timescale 1ns/1ns
module eliu_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pslverr,
   input wire logic module_stop,
   input wire eliu_pkg::eliu_nmi_src_type nmi_src,
   input wire logic [95:0] core_irq,
   input wire logic [95:0] core_ack,
   input wire logic [95:0] xfer_ack,
   input wire eliu_pkg::eliu_lp_type lp_mode,
   input wire logic nmi_req,
   input wire logic wake_req
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire logic clr_wr;
   assign clr_wr = psel && penable && pwrite && !module_stop && paddr == 12'h04C;
   // ----------------------------------------
   // non-maskable merge
   // ----------------------------------------
   parity_nmi_a: assert property (nmi_src.sram_parity_error_event |=> nmi_req)
      else $error("parity event gave no nmi");
   ecc_nmi_a: assert property (nmi_src.sram_correction_error_event |=> nmi_req)
      else $error("correction event gave no nmi");
   slave_nmi_a: assert property (nmi_src.bus_slave_error_event |=> nmi_req)
      else $error("slave error gave no nmi");
   master_nmi_a: assert property (nmi_src.bus_master_error_event |=> nmi_req)
      else $error("master error gave no nmi");
   stack_nmi_a: assert property (nmi_src.stack_pointer_error_event |=> nmi_req)
      else $error("stack error gave no nmi");
   nmi_hold_a: assert property ($fell(nmi_req) |-> $past(clr_wr))
      else $error("nmi fell without clear write");
   // ----------------------------------------
   // wake, slot requests and error response
   // ----------------------------------------
   sleep_wake_a: assert property (lp_mode == eliu_pkg::ELIU_LP_SLEEP && nmi_req |=> wake_req)
      else $error("no wake from sleep");
   standby_wake_a: assert property (lp_mode == eliu_pkg::ELIU_LP_STANDBY && nmi_req |=> wake_req)
      else $error("no wake from standby");
   snooze_wake_a: assert property (lp_mode == eliu_pkg::ELIU_LP_SNOOZE && nmi_req |=> wake_req)
      else $error("no wake from snooze");
   wake_idle_a: assert property ((lp_mode == eliu_pkg::ELIU_LP_NORMAL) [*2] |-> !wake_req)
      else $error("wake held in normal mode");
   irq_hold_a: assert property ($fell(core_irq[0]) |-> $past(core_ack[0] || xfer_ack[0] || psel))
      else $error("slot request dropped without accept");
   slverr_phase_a: assert property (pslverr |-> psel && penable && !module_stop)
      else $error("error response outside access");
   nmi_clear_c: cover property (clr_wr && nmi_req);
   wake_c: cover property ($rose(wake_req));
   irq_done_c: cover property ($fell(core_irq[0]));
endmodule

bind eliu_event_link_interrupt_unit eliu_asserts u_asserts (.pclk(pclk), .presetn(presetn), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pslverr(pslverr), .module_stop(module_stop),
   .nmi_src(nmi_src), .core_irq(core_irq), .core_ack(core_ack), .xfer_ack(xfer_ack), .lp_mode(lp_mode),
   .nmi_req(nmi_req), .wake_req(wake_req));

// *** eliu_consumer_model.sv ***
// consumer model: core controller, transfer engine or dma channel
// assumes level requests that drop the cycle after a one-cycle accept
`timescale 1ns/1ns
module eliu_consumer_model #(
   parameter int W = 96
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] latency,
   input wire logic [W-1:0] req,
   output logic [W-1:0] ack
);
   logic [3:0] cnt_q;
   // accepts the lowest pending request after latency cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 4'h0;
         ack <= '0;
      end else if (ack != '0 || req == '0) begin
         cnt_q <= 4'h0;
         ack <= '0;
      end else if (cnt_q >= latency) begin
         ack <= req & (~req + 1'b1);
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule

// *** eliu_defs.svh ***
// register offsets, field positions and reset values of the event link interrupt unit
// assumes a 12-bit apb byte address and 32-bit data
`ifndef ELIU_DEFS_SVH
`define ELIU_DEFS_SVH

`define ELIU_PIN_CFG_BASE 12'h000
`define ELIU_NMI_CFG 12'h040
`define ELIU_NMI_EN 12'h044
`define ELIU_NMI_STAT 12'h048
`define ELIU_NMI_CLR 12'h04C
`define ELIU_WAKE_MASK 12'h050
`define ELIU_SNZ_SEL 12'h054
`define ELIU_PIN_LEVEL 12'h058
`define ELIU_SLOT_PEND_BASE 12'h060
`define ELIU_DMA_SEL_BASE 12'h080
`define ELIU_SLOT_SEL_BASE 12'h200

`define ELIU_NUM_PINS 16
`define ELIU_NUM_SLOTS 96
`define ELIU_NUM_DMA 8
`define ELIU_NUM_NMI 11
`define ELIU_PERIPH_FIRST 9'h040
`define ELIU_PIN_EVT_FIRST 9'h001
`define ELIU_PIN_EVT_LAST 9'h010

`define ELIU_CFG_SENSE_LSB 0
`define ELIU_CFG_FEN_BIT 2
`define ELIU_CFG_FCLK_LSB 3
`define ELIU_SLOT_EVT_LSB 0
`define ELIU_SLOT_CORE_BIT 9
`define ELIU_SLOT_XFER_BIT 10
`define ELIU_WAKE_SNZ_BIT 31

`define ELIU_PIN_CFG_RST 5'h00
`define ELIU_SLOT_CFG_RST 11'h000
`define ELIU_SEL_RST 9'h000
`define ELIU_NMI_EN_RST 11'h000
`define ELIU_NMI_FIXED 11'h7C0
`define ELIU_WAKE_RST 32'h00000000
`define ELIU_PIN_IDLE 1'b1
`define ELIU_FILT_SAMPLES 3

`endif

// *** eliu_event_link_interrupt_unit.sv ***
// event link interrupt unit: event routing, pin interrupts, nmi merge, wake gating
// assumes apb master on pclk, pins and events synchronous to pclk
//
// Summary of operation
// - route selected events to core and transfer slots
// - slot picks event number 1 to 16 (pins) or 64 to 511
// - sixteen external request pins, own events
// - low, falling, rising, both; optional filter
// - one detection method per pin
// - slot may trigger transfer, core, or both
// - nmi pin edge selectable, filter supported
// - oscillator stop raises nmi when enabled
// - watchdog faults raise nmi when enabled
// - voltage detector events raise nmi when enabled
// - sram parity error raises nmi
// - sram correction error raises nmi
// - bus slave error raises nmi
// - bus master error raises nmi
// - stack pointer violation raises nmi
// - sleep wakes on nmi or any interrupt
// - standby wakes on nmi or masked interrupts
// - snooze wakes on nmi or selected masked event
//
// The implementer's own choices: the APB register port and the address map.
`include "eliu_defs.svh"
`timescale 1ns/1ns

module eliu_event_link_interrupt_unit (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic module_stop,
   input wire logic [15:0] external_request_pin,
   input wire logic nmi_pin,
   input wire logic [447:0] periph_evt,
   input wire eliu_pkg::eliu_nmi_src_type nmi_src,
   output logic [95:0] core_irq,
   input wire logic [95:0] core_ack,
   output logic [95:0] xfer_req,
   input wire logic [95:0] xfer_ack,
   output logic [7:0] dma_req,
   input wire logic [7:0] dma_ack,
   input wire eliu_pkg::eliu_lp_type lp_mode,
   output logic nmi_req,
   output logic wake_req
);

   // ------------------------------------------------------------
   // registers and shared nets
   // ------------------------------------------------------------
   eliu_pkg::eliu_pin_cfg_type pin_cfg_q [0:16];
   eliu_pkg::eliu_slot_cfg_type slot_cfg_q [0:95];
   logic [8:0] dma_sel_q [0:7];
   logic [8:0] snz_sel_q;
   logic [31:0] wake_mask_q;
   logic [10:0] nmi_en_q;
   logic [10:0] nmi_stat_q;
   logic [31:0] prdata_q;
   logic [5:0] div_cnt_q;
   logic wake_q;
   logic [95:0] slot_pend_q;
   logic [7:0] dma_pend_q;
   logic [16:0] filt_lvl;
   logic [16:0] ch_fall;
   logic [16:0] ch_rise;
   logic [15:0] pin_pulse;
   logic [15:0] pin_level;
   logic [511:0] evt_pulse;
   logic [511:0] evt_level;
   logic [95:0] slot_req;
   logic [3:0] tick_sel;

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   // while the module is stopped the registers are unreachable: reads give zero, writes are dropped
   wire bus_open = ~module_stop;
   wire wr_en = psel & penable & pwrite & bus_open;
   wire setup = psel & ~penable;
   wire [6:0] word_idx = paddr[8:2];
   wire pin_hit = (paddr[11:6] == 6'h00);
   wire slot_hit = (paddr[11:9] == 3'h1) && (word_idx < 7'd96) && (paddr[1:0] == 2'h0);
   wire dma_hit = (paddr[11:5] == 7'h04) && (paddr[1:0] == 2'h0);
   wire pend_hit = (paddr >= `ELIU_SLOT_PEND_BASE) && (paddr < 12'h06C) && (paddr[1:0] == 2'h0);
   wire nmi_cfg_hit = (paddr == `ELIU_NMI_CFG);
   wire nmi_en_hit = (paddr == `ELIU_NMI_EN);
   wire nmi_stat_hit = (paddr == `ELIU_NMI_STAT);
   wire nmi_clr_hit = (paddr == `ELIU_NMI_CLR);
   wire wake_hit = (paddr == `ELIU_WAKE_MASK);
   wire snz_hit = (paddr == `ELIU_SNZ_SEL);
   wire lvl_hit = (paddr == `ELIU_PIN_LEVEL);
   wire any_hit = pin_hit | slot_hit | dma_hit | pend_hit | nmi_cfg_hit | nmi_en_hit | nmi_stat_hit
      | nmi_clr_hit | wake_hit | snz_hit | lvl_hit;
   wire [6:0] slot_idx = word_idx - 7'd0;
   wire [1:0] pend_idx = paddr[3:2] - 2'h0;
   wire [2:0] dma_idx = paddr[4:2];
   wire [3:0] pin_idx = paddr[5:2];
   wire [31:0] pend_word = (pend_idx == 2'h0) ? slot_pend_q[31:0] :
      (pend_idx == 2'h1) ? slot_pend_q[63:32] : slot_pend_q[95:64];

   wire [31:0] rd_data =
      ~bus_open ? 32'h00000000 :
      pin_hit ? {27'h0000000, pin_cfg_q[pin_idx]} :
      slot_hit ? {21'h000000, slot_cfg_q[slot_idx]} :
      dma_hit ? {23'h000000, dma_sel_q[dma_idx]} :
      pend_hit ? pend_word :
      nmi_cfg_hit ? {27'h0000000, pin_cfg_q[16]} :
      nmi_en_hit ? {21'h000000, nmi_en_q | `ELIU_NMI_FIXED} :
      nmi_stat_hit ? {21'h000000, nmi_stat_q} :
      wake_hit ? wake_mask_q :
      snz_hit ? {23'h000000, snz_sel_q} :
      lvl_hit ? {15'h0000, filt_lvl} : 32'h00000000;

   // zero wait state; read data is captured in the setup cycle
   assign pready = 1'b1;
   assign pslverr = psel & penable & bus_open & ~any_hit;
   assign prdata = prdata_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
      end else if (setup) begin
         prdata_q <= rd_data;
      end
   end

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 17; gi++) begin : g_pin_cfg
         logic hit;
         // the last entry is the nmi pin, which has its own address
         if (gi < 16) begin : g_pin
            assign hit = pin_hit && (pin_idx == 4'(gi));
         end else begin : g_nmi
            assign hit = nmi_cfg_hit;
         end
         // one sense field per pin, so exactly one method applies
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_cfg_q[gi] <= `ELIU_PIN_CFG_RST;
            end else if (wr_en && hit) begin
               pin_cfg_q[gi] <= pwdata[4:0];
            end
         end
      end
      for (gi = 0; gi < 96; gi++) begin : g_slot_cfg
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               slot_cfg_q[gi] <= `ELIU_SLOT_CFG_RST;
            end else if (wr_en && slot_hit && slot_idx == 7'(gi)) begin
               slot_cfg_q[gi] <= pwdata[10:0];
            end
         end
      end
      for (gi = 0; gi < 8; gi++) begin : g_dma_cfg
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               dma_sel_q[gi] <= `ELIU_SEL_RST;
            end else if (wr_en && dma_hit && dma_idx == 3'(gi)) begin
               dma_sel_q[gi] <= pwdata[8:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_mask_q <= `ELIU_WAKE_RST;
         snz_sel_q <= `ELIU_SEL_RST;
         nmi_en_q <= `ELIU_NMI_EN_RST;
      end else begin
         if (wr_en && wake_hit) begin
            wake_mask_q <= pwdata;
         end
         if (wr_en && snz_hit) begin
            snz_sel_q <= pwdata[8:0];
         end
         // write one to set; no path clears it short of reset
         if (wr_en && nmi_en_hit) begin
            nmi_en_q <= nmi_en_q | pwdata[10:0];
         end
      end
   end

   // ------------------------------------------------------------
   // pin filters and detectors (16 pins plus the nmi pin)
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_q <= 6'h00;
      end else begin
         div_cnt_q <= div_cnt_q + 6'h01;
      end
   end

   assign tick_sel = {div_cnt_q == 6'h00, div_cnt_q[4:0] == 5'h00, div_cnt_q[2:0] == 3'h0, 1'b1};

   generate
      for (gi = 0; gi < 17; gi++) begin : g_filt
         logic raw;
         // a select on the pin vector must stay in range, so the nmi entry is split off here
         if (gi < 16) begin : g_ext
            assign raw = external_request_pin[gi];
         end else begin : g_nmi
            assign raw = nmi_pin;
         end
         wire tick = tick_sel[pin_cfg_q[gi].fclk];
         logic [2:0] samp_q;
         logic filt_q;
         logic prev_q;
         wire stable = (samp_q == 3'h7) | (samp_q == 3'h0);
         // filter takes a new level only after three equal samples
         wire filt_d = ~pin_cfg_q[gi].fen ? raw : (tick && stable) ? samp_q[0] : filt_q;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               samp_q <= {`ELIU_FILT_SAMPLES{`ELIU_PIN_IDLE}};
               filt_q <= `ELIU_PIN_IDLE;
               prev_q <= `ELIU_PIN_IDLE;
            end else begin
               if (tick) begin
                  samp_q <= {samp_q[1:0], raw};
               end
               filt_q <= filt_d;
               prev_q <= filt_q;
            end
         end
         assign filt_lvl[gi] = filt_q;
         assign ch_fall[gi] = prev_q & ~filt_q;
         assign ch_rise[gi] = ~prev_q & filt_q;
      end
      for (gi = 0; gi < 16; gi++) begin : g_sense
         wire eliu_pkg::eliu_sense_type sense = pin_cfg_q[gi].sense;
         assign pin_pulse[gi] = (sense == eliu_pkg::ELIU_SENSE_FALL) ? ch_fall[gi] :
            (sense == eliu_pkg::ELIU_SENSE_RISE) ? ch_rise[gi] :
            (sense == eliu_pkg::ELIU_SENSE_BOTH) ? (ch_fall[gi] | ch_rise[gi]) : 1'b0;
         assign pin_level[gi] = (sense == eliu_pkg::ELIU_SENSE_LOW) & ~filt_lvl[gi];
      end
   endgenerate

   // event numbers: 1..16 are the pins, 64..511 the peripherals
   assign evt_pulse = {periph_evt, 47'h000000000000, pin_pulse, 1'b0};
   assign evt_level = {448'h0, 47'h000000000000, pin_level, 1'b0};

   function automatic logic sel_valid(input logic [8:0] sel);
      sel_valid = (sel >= `ELIU_PERIPH_FIRST) || (sel >= `ELIU_PIN_EVT_FIRST && sel <= `ELIU_PIN_EVT_LAST);
   endfunction

   // ------------------------------------------------------------
   // output slots toward core and transfer engines
   // ------------------------------------------------------------
   generate
      for (gi = 0; gi < 96; gi++) begin : g_slot
         wire eliu_pkg::eliu_slot_cfg_type cfg = slot_cfg_q[gi];
         wire ok = sel_valid(cfg.evt);
         wire hit_p = ok & evt_pulse[cfg.evt];
         wire hit_l = ok & evt_level[cfg.evt];
         wire taken = (core_ack[gi] & cfg.core_en) | (xfer_ack[gi] & cfg.xfer_en);
         // a new event in the accept cycle survives the clear
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               slot_pend_q[gi] <= 1'b0;
            end else begin
               slot_pend_q[gi] <= hit_p | (slot_pend_q[gi] & ~taken);
            end
         end
         assign slot_req[gi] = slot_pend_q[gi] | hit_l;
         assign core_irq[gi] = slot_req[gi] & cfg.core_en;
         assign xfer_req[gi] = slot_req[gi] & cfg.xfer_en;
      end
      for (gi = 0; gi < 8; gi++) begin : g_dma
         wire [8:0] sel = dma_sel_q[gi];
         wire ok = sel_valid(sel);
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               dma_pend_q[gi] <= 1'b0;
            end else begin
               dma_pend_q[gi] <= (ok & evt_pulse[sel]) | (dma_pend_q[gi] & ~dma_ack[gi]);
            end
         end
         assign dma_req[gi] = dma_pend_q[gi] | (ok & evt_level[sel]);
      end
   endgenerate

   // ------------------------------------------------------------
   // non-maskable merge
   // ------------------------------------------------------------
   // bit 0 nmi pin, 1 osc stop, 2..3 watchdogs, 4..5 voltage, 6..10 always armed
   wire nmi_pin_evt = pin_cfg_q[16].sense[0] ? ch_rise[16] : ch_fall[16];
   wire [10:0] nmi_evt = {nmi_src, nmi_pin_evt};
   wire [10:0] nmi_arm = nmi_en_q | `ELIU_NMI_FIXED;
   wire [10:0] nmi_clr = (wr_en && nmi_clr_hit) ? pwdata[10:0] : 11'h000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_stat_q <= 11'h000;
      end else begin
         nmi_stat_q <= (nmi_evt & nmi_arm) | (nmi_stat_q & ~nmi_clr);
      end
   end

   assign nmi_req = |nmi_stat_q;

   // ------------------------------------------------------------
   // wake-up gating
   // ------------------------------------------------------------
   wire [8:0] snz = snz_sel_q;
   wire snz_evt = sel_valid(snz) & (evt_pulse[snz] | evt_level[snz]);
   wire [15:0] pin_any = pin_pulse | pin_level;
   wire wake_sleep = nmi_req | (|(core_irq | xfer_req));
   wire wake_standby = nmi_req | (|(wake_mask_q[15:0] & pin_any)) | (|(wake_mask_q[30:16] & slot_req[14:0]));
   wire wake_snooze = nmi_req | (wake_mask_q[`ELIU_WAKE_SNZ_BIT] & snz_evt);
   wire wake_cause = (lp_mode == eliu_pkg::ELIU_LP_SLEEP) ? wake_sleep :
      (lp_mode == eliu_pkg::ELIU_LP_STANDBY) ? wake_standby :
      (lp_mode == eliu_pkg::ELIU_LP_SNOOZE) ? wake_snooze : 1'b0;

   // held until the system is back in normal mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= wake_cause | (wake_q & (lp_mode != eliu_pkg::ELIU_LP_NORMAL));
      end
   end

   assign wake_req = wake_q;

endmodule

// *** eliu_pkg.sv ***
// types shared by the event link interrupt unit and its bench
// assumes eliu_defs.svh supplies every number
package eliu_pkg;

   typedef enum logic [1:0] {
      ELIU_SENSE_FALL = 2'h0,
      ELIU_SENSE_RISE = 2'h1,
      ELIU_SENSE_BOTH = 2'h2,
      ELIU_SENSE_LOW = 2'h3
   } eliu_sense_type;

   typedef enum logic [1:0] {
      ELIU_LP_NORMAL = 2'h0,
      ELIU_LP_SLEEP = 2'h1,
      ELIU_LP_STANDBY = 2'h2,
      ELIU_LP_SNOOZE = 2'h3
   } eliu_lp_type;

   // filter sample clock: pclk/1, /8, /32, /64
   typedef struct packed {
      logic [1:0] fclk;
      logic fen;
      eliu_sense_type sense;
   } eliu_pin_cfg_type;

   typedef struct packed {
      logic xfer_en;
      logic core_en;
      logic [8:0] evt;
   } eliu_slot_cfg_type;

   // non-maskable sources other than the pin, level or pulse, high active
   typedef struct packed {
      logic stack_pointer_error_event;
      logic bus_master_error_event;
      logic bus_slave_error_event;
      logic sram_correction_error_event;
      logic sram_parity_error_event;
      logic voltage_detector_two;
      logic voltage_detector_one;
      logic independent_watchdog;
      logic window_watchdog;
      logic osc_stop;
   } eliu_nmi_src_type;

endpackage

// *** tb.sv ***
// self-checking bench of the event link interrupt unit
// assumes consumer models answer core, transfer and dma requests
`timescale 1ns/1ns
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, module_stop, nmi_pin, nmi_req, wake_req, slv;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] ext_pin;
   logic [447:0] periph_evt;
   logic [95:0] core_irq, core_ack, xfer_req, xfer_ack;
   logic [7:0] dma_req, dma_ack;
   logic [3:0] lat;
   eliu_pkg::eliu_nmi_src_type nmi_src;
   eliu_pkg::eliu_lp_type lp_mode;
   int err_count, comparisons;
   logic [31:0] wmask [4] = '{32'h0, 32'h10000, 32'h80000000, 32'h0};
   eliu_pkg::eliu_lp_type wlp [4] = '{eliu_pkg::ELIU_LP_STANDBY, eliu_pkg::ELIU_LP_STANDBY,
      eliu_pkg::ELIU_LP_SNOOZE, eliu_pkg::ELIU_LP_SLEEP};
   always #5 pclk = ~pclk;
   eliu_event_link_interrupt_unit u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .module_stop(module_stop), .external_request_pin(ext_pin), .nmi_pin(nmi_pin),
      .periph_evt(periph_evt), .nmi_src(nmi_src), .core_irq(core_irq), .core_ack(core_ack),
      .xfer_req(xfer_req), .xfer_ack(xfer_ack), .dma_req(dma_req), .dma_ack(dma_ack),
      .lp_mode(lp_mode), .nmi_req(nmi_req), .wake_req(wake_req));
   eliu_consumer_model #(.W(96)) u_core (.pclk(pclk), .presetn(presetn), .latency(lat), .req(core_irq),
      .ack(core_ack));
   eliu_consumer_model #(.W(96)) u_xfer (.pclk(pclk), .presetn(presetn), .latency(lat), .req(xfer_req),
      .ack(xfer_ack));
   eliu_consumer_model #(.W(8)) u_dma (.pclk(pclk), .presetn(presetn), .latency(lat), .req(dma_req),
      .ack(dma_ack));
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic summarize();
      $display("mismatches %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      tick(1);
      penable <= 1'b1;
      tick(1);
      while (pready !== 1'b1) begin
         n++;
         if (n > 20) begin
            chk("apb_wait", 32'h0, 32'h1);
            summarize();
         end
         tick(1);
      end
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      tick(1);
   endtask
   task automatic wait_drop();
      int n;
      n = 0;
      while ({core_irq, xfer_req, dma_req} !== '0) begin
         n++;
         if (n > 100) begin
            chk("drop_wait", 32'h0, 32'h1);
            summarize();
         end
         tick(1);
      end
   endtask
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, module_stop} = 4'h0;
      {nmi_pin, ext_pin} = 17'h1FFFF;
      paddr = 12'h000;
      pwdata = 32'h0;
      periph_evt = '0;
      nmi_src = '0;
      lp_mode = eliu_pkg::ELIU_LP_NORMAL;
      lat = 4'h6;
      err_count = 0;
      comparisons = 0;
      tick(8);
      presetn <= 1'b1;
      tick(1);
      apb(1'b0, 12'h044, 32'h0);
      chk("nmi_en_rst", 32'h7C0, rd);
      apb(1'b0, 12'h070, 32'h0);
      chk("unmapped", 32'h1, {31'h0, slv});
      module_stop <= 1'b1;
      apb(1'b1, 12'h044, 32'h1);
      apb(1'b0, 12'h044, 32'h0);
      chk("stopped_rd", 32'h0, rd);
      module_stop <= 1'b0;
      apb(1'b0, 12'h044, 32'h0);
      chk("stop_ignored", 32'h7C0, rd);
      apb(1'b1, 12'h200, 32'h240);
      apb(1'b1, 12'h204, 32'h5FF);
      apb(1'b1, 12'h208, 32'h664);
      apb(1'b1, 12'h20C, 32'h23F);
      apb(1'b1, 12'h080, 32'h64);
      periph_evt <= '1;
      tick(1);
      periph_evt <= '0;
      @(negedge pclk);
      chk("slot_core", 32'h5, {28'h0, core_irq[3:0]});
      chk("slot_xfer", 32'h6, {28'h0, xfer_req[3:0]});
      chk("dma_req", 32'h1, {24'h0, dma_req});
      tick(3);
      @(negedge pclk);
      chk("slot_held", 32'h5, {28'h0, core_irq[3:0]});
      tick(1);
      wait_drop();
      lat <= 4'hF;
      for (int i = 0; i < 16; i++) begin
         apb(1'b1, 12'(4 * i), 32'(i % 4));
         apb(1'b1, 12'h210 + 12'(4 * i), 32'h200 + 32'(i + 1));
         ext_pin[i] <= 1'b0;
         tick(6);
         @(negedge pclk);
         chk("pin_low", 32'(i % 4 != 1), 32'(core_irq[4 + i]));
         tick(1);
         ext_pin[i] <= 1'b1;
         tick(6);
         @(negedge pclk);
         chk("pin_high", 32'(i % 4 != 3), 32'(core_irq[4 + i]));
         tick(1);
         wait_drop();
      end
      apb(1'b1, 12'h000, 32'h4);
      ext_pin[0] <= 1'b0;
      tick(2);
      ext_pin[0] <= 1'b1;
      tick(8);
      @(negedge pclk);
      chk("filt_glitch", 32'h0, 32'(core_irq[4]));
      tick(1);
      ext_pin[0] <= 1'b0;
      tick(3);
      @(negedge pclk);
      chk("filt_delay", 32'h0, 32'(core_irq[4]));
      tick(2);
      @(negedge pclk);
      chk("filt_fall", 32'h1, 32'(core_irq[4]));
      tick(1);
      apb(1'b0, 12'h060, 32'h0);
      chk("slot_pend", 32'h10, rd);
      apb(1'b0, 12'h058, 32'h0);
      chk("pin_levels", 32'h1FFFE, rd);
      ext_pin[0] <= 1'b1;
      wait_drop();
      lat <= 4'h6;
      nmi_src.osc_stop <= 1'b1;
      tick(1);
      nmi_src.osc_stop <= 1'b0;
      tick(1);
      @(negedge pclk);
      chk("nmi_masked", 32'h0, 32'(nmi_req));
      tick(1);
      apb(1'b1, 12'h044, 32'h3F);
      apb(1'b1, 12'h04C, 32'h7FF);
      apb(1'b1, 12'h044, 32'h0);
      apb(1'b0, 12'h044, 32'h0);
      chk("nmi_en_sticky", 32'h7FF, rd);
      for (int b = 0; b < 10; b++) begin
         lp_mode <= eliu_pkg::eliu_lp_type'(b % 4);
         nmi_src <= eliu_pkg::eliu_nmi_src_type'(10'h1 << b);
         tick(1);
         nmi_src <= '0;
         tick(1);
         @(negedge pclk);
         chk("nmi_req", 32'h1, 32'(nmi_req));
         chk("wake_nmi", 32'(b % 4 != 0), 32'(wake_req));
         tick(1);
         lp_mode <= eliu_pkg::ELIU_LP_NORMAL;
         apb(1'b0, 12'h048, 32'h0);
         chk("nmi_stat", 32'h1 << (b + 1), rd);
         apb(1'b1, 12'h04C, 32'h7FF);
         @(negedge pclk);
         chk("nmi_clear", 32'h0, 32'(nmi_req));
         tick(1);
      end
      apb(1'b1, 12'h040, 32'h1);
      nmi_pin <= 1'b0;
      tick(6);
      apb(1'b0, 12'h048, 32'h0);
      chk("nmi_pin_fall", 32'h0, rd);
      nmi_pin <= 1'b1;
      tick(6);
      apb(1'b0, 12'h048, 32'h0);
      chk("nmi_pin_rise", 32'h1, rd);
      apb(1'b1, 12'h04C, 32'h1);
      apb(1'b1, 12'h054, 32'h40);
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, 12'h050, wmask[k]);
         lp_mode <= wlp[k];
         periph_evt[0] <= 1'b1;
         tick(1);
         periph_evt[0] <= 1'b0;
         tick(2);
         @(negedge pclk);
         chk("wake_evt", 32'(k != 0), 32'(wake_req));
         tick(1);
         lp_mode <= eliu_pkg::ELIU_LP_NORMAL;
         wait_drop();
      end
      summarize();
   end
endmodule
